// ==== src/i2e_pkg.sv ====
package i2e_pkg;

  // ----------------------------------------------------------------
  // Bus timing, counted on the link clock
  // ----------------------------------------------------------------
  localparam int unsigned LCLK_PERIOD_NS = 6;     // Link clock period
  localparam int unsigned T_LOW_NS       = 4700;  // Least SCL low time
  localparam int unsigned T_HIGH_NS      = 4000;  // Least SCL high time
  localparam int unsigned T_HOLD_NS      = 300;   // Data hold after SCL fall
  localparam int unsigned CNT_W          = 12;    // Width of the phase counter

  // Least times round up to whole link clock cycles
  localparam int unsigned LOW_CYC_DEF  = (T_LOW_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;
  localparam int unsigned HIGH_CYC_DEF = (T_HIGH_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;
  localparam int unsigned HOLD_CYC_DEF = (T_HOLD_NS + LCLK_PERIOD_NS - 1) / LCLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Byte framing and pin levels
  // ----------------------------------------------------------------
  localparam logic [3:0] BIT_FIRST = 4'h0;   // First data bit of a byte
  localparam logic [3:0] ACK_BIT   = 4'h8;   // Ninth slot carries the acknowledge
  localparam logic       PIN_LOW   = 1'b0;   // Open-drain outputs only ever pull low
  localparam logic       LINE_IDLE = 1'b1;   // Released line level after reset
  localparam logic       RDY_RST   = 1'b1;   // Command port ready after reset

  // ----------------------------------------------------------------
  // Commands, answers and engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_START  = 3'h0,   // Start, or repeated start when the bus is ours
    OP_STOP   = 3'h1,
    OP_WRITE  = 3'h2,   // Master sends a byte, reads the acknowledge
    OP_READ   = 3'h3,   // Master takes a byte, sends ack_out
    OP_SLV_TX = 3'h4,   // Slave sends a byte on the remote clock
    OP_SLV_RX = 3'h5    // Slave takes a byte on the remote clock
  } i2e_op_e;

  typedef struct packed {
    logic       valid;
    i2e_op_e    op;
    logic [7:0] data;
    logic       ack_out;   // Level sent in the acknowledge slot, 0 = ack
  } i2e_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;      // Byte seen on the bus, MSB first
    logic       ack_in;    // Acknowledge level sampled, 0 = ack
    logic       arb_lost;  // Arbitration was lost during this command
  } i2e_rsp_s;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_RS_A   = 4'h1,
    ST_RS_B   = 4'h2,
    ST_RS_C   = 4'h3,
    ST_LOW    = 4'h4,
    ST_HIGH   = 4'h5,
    ST_STOP_A = 4'h6,
    ST_STOP_B = 4'h7,
    ST_STOP_C = 4'h8,
    ST_SLV    = 4'h9,
    ST_DONE   = 4'ha
  } i2e_state_e;

endpackage : i2e_pkg

// ==== src/i2e_engine.sv ====
`timescale 1ns/100ps
module i2e_engine #(
  parameter logic [i2e_pkg::CNT_W-1:0] LOW_CYC  = i2e_pkg::CNT_W'(i2e_pkg::LOW_CYC_DEF),
  parameter logic [i2e_pkg::CNT_W-1:0] HIGH_CYC = i2e_pkg::CNT_W'(i2e_pkg::HIGH_CYC_DEF),
  parameter logic [i2e_pkg::CNT_W-1:0] HOLD_CYC = i2e_pkg::CNT_W'(i2e_pkg::HOLD_CYC_DEF)
) (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        lclk,
  input  i2e_pkg::i2e_cmd_s cmd,
  output logic             cmd_ready,
  output i2e_pkg::i2e_rsp_s rsp,
  output logic             bus_busy,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_n
);
  import i2e_pkg::*;

  // ----------------------------------------------------------------
  // State of each clock domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic     req_t;    // Toggles once per command handed over
    logic     ack_s1;
    logic     ack_s2;
    logic     ack_seen;
    i2e_cmd_s cmd_q;    // Held stable until the link side answers
    logic     ready;
    i2e_rsp_s rsp;
    logic     bsy_s1;
    logic     bsy_s2;
  } i2e_mst_s;

  typedef struct packed {
    logic             scl_s1;
    logic             scl_s2;
    logic             scl_p;
    logic             sda_s1;
    logic             sda_s2;
    logic             sda_p;
    logic             req_s1;
    logic             req_s2;
    logic             req_seen;
    logic             ack_t;
    i2e_op_e          op;
    logic             ack_out;
    logic [7:0]       shreg;
    logic [3:0]       bitcnt;
    logic [CNT_W-1:0] cnt;
    i2e_state_e       st;
    logic             sda_rel;  // 1 = SDA released to the pull-up
    logic             scl_rel;  // 1 = SCL released to the pull-up
    logic             busy;
    logic             owner;    // We issued the start that made the bus busy
    logic             arb;
    logic [7:0]       rdata;
    logic             ack_in;
  } i2e_lnk_s;

  i2e_mst_s mq;
  i2e_mst_s md;
  i2e_lnk_s lq;
  i2e_lnk_s ld;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic is_tx(input i2e_op_e op);
    is_tx = (op == OP_WRITE) || (op == OP_SLV_TX);
  endfunction : is_tx

  // Level to put on SDA for a bit slot; MSB leaves first
  function automatic logic drv_bit(input i2e_op_e op, input logic [3:0] bitcnt,
                                   input logic msb, input logic ack_out);
    if (bitcnt == ACK_BIT) begin
      drv_bit = is_tx(op) ? LINE_IDLE : ack_out;
    end else begin
      drv_bit = is_tx(op) ? msb : LINE_IDLE;
    end
  endfunction : drv_bit

  // ----------------------------------------------------------------
  // System clock side: command hand-over and answer capture
  // ----------------------------------------------------------------
  // Toggle handshake keeps the payload still while the link reads it
  always_comb begin
    md            = mq;
    md.ack_s1     = lq.ack_t;
    md.ack_s2     = mq.ack_s1;
    md.bsy_s1     = lq.busy;
    md.bsy_s2     = mq.bsy_s1;
    md.rsp.valid  = 1'b0;
    if (cmd.valid && mq.ready) begin
      md.cmd_q = cmd;
      md.req_t = ~mq.req_t;
      md.ready = 1'b0;
    end
    if (mq.ack_s2 != mq.ack_seen) begin
      md.ack_seen     = mq.ack_s2;
      md.ready        = RDY_RST;
      md.rsp.valid    = 1'b1;
      md.rsp.data     = lq.rdata;
      md.rsp.ack_in   = lq.ack_in;
      md.rsp.arb_lost = lq.arb;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mq       <= '0;
      mq.ready <= RDY_RST;
    end else begin
      mq <= md;
    end
  end

  // ----------------------------------------------------------------
  // Link clock side: bus conditions
  // ----------------------------------------------------------------
  logic scl_hi;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic new_req;
  logic take;
  logic smp_bit;
  logic arb_ev;

  // Only the second synchroniser stage and later feed any detection
  assign scl_hi    = lq.scl_s2;
  assign scl_rise  = lq.scl_s2 & ~lq.scl_p;
  assign scl_fall  = ~lq.scl_s2 & lq.scl_p;
  assign start_det = lq.scl_s2 & lq.scl_p & lq.sda_p & ~lq.sda_s2;
  assign stop_det  = lq.scl_s2 & lq.scl_p & ~lq.sda_p & lq.sda_s2;
  assign new_req   = lq.req_s2 != lq.req_seen;
  // A fresh start waits here while someone else holds the bus
  assign take      = new_req && !(mq.cmd_q.op == OP_START && !lq.owner && lq.busy);
  // Sample point: first cycle SCL is seen high in master mode, rise in slave mode
  assign smp_bit   = (lq.st == ST_HIGH && scl_hi && lq.cnt == '0) ||
                     (lq.st == ST_SLV && scl_rise);
  // We let SDA float for a data bit but the line reads low
  assign arb_ev    = smp_bit && is_tx(lq.op) && lq.bitcnt != ACK_BIT &&
                     lq.sda_rel && !lq.sda_s2;

  // ----------------------------------------------------------------
  // Link clock side: bit engine
  // ----------------------------------------------------------------
  always_comb begin
    ld        = lq;
    ld.scl_s1 = scl_i;
    ld.scl_s2 = lq.scl_s1;
    ld.scl_p  = lq.scl_s2;
    ld.sda_s1 = sda_i;
    ld.sda_s2 = lq.sda_s1;
    ld.sda_p  = lq.sda_s2;
    ld.req_s1 = mq.req_t;
    ld.req_s2 = lq.req_s1;
    ld.cnt    = lq.cnt + CNT_W'(1);
    if (start_det) begin
      ld.busy = 1'b1;
    end else if (stop_det) begin
      ld.busy = 1'b0;
    end
    // Sampled bus bit goes into the shifter, ninth slot is the acknowledge
    if (smp_bit) begin
      if (lq.bitcnt == ACK_BIT) begin
        ld.ack_in = lq.sda_s2;
      end else begin
        ld.shreg = {lq.shreg[6:0], lq.sda_s2};
      end
    end
    case (lq.st)
      ST_IDLE: begin
        if (take) begin
          ld.req_seen = lq.req_s2;
          ld.op       = mq.cmd_q.op;
          ld.shreg    = mq.cmd_q.data;   // First write after start is address plus R/W
          ld.ack_out  = mq.cmd_q.ack_out;
          ld.bitcnt   = BIT_FIRST;
          ld.cnt      = '0;
          ld.arb      = 1'b0;
          case (mq.cmd_q.op)
            OP_START:  ld.st = lq.owner ? ST_RS_A : ST_RS_B;
            OP_STOP:   ld.st = lq.owner ? ST_STOP_A : ST_DONE;
            OP_WRITE,
            OP_READ:   ld.st = ST_LOW;
            OP_SLV_TX,
            OP_SLV_RX: begin
              ld.st      = ST_SLV;
              ld.sda_rel = drv_bit(mq.cmd_q.op, BIT_FIRST, mq.cmd_q.data[7],
                                   mq.cmd_q.ack_out);
            end
            default:   ld.st = ST_DONE;
          endcase
        end
      end
      // Repeated start: float SDA while SCL is low, then raise SCL
      ST_RS_A: begin
        ld.sda_rel = 1'b1;
        if (lq.cnt == LOW_CYC) begin
          ld.scl_rel = 1'b1;
          ld.cnt     = '0;
          ld.st      = ST_RS_B;
        end
      end
      ST_RS_B: begin
        if (!scl_hi) begin
          ld.cnt = '0;
        end else if (lq.cnt == HIGH_CYC) begin
          ld.cnt = '0;
          if (!lq.sda_s2) begin
            ld.arb     = 1'b1;
            ld.scl_rel = 1'b1;
            ld.st      = ST_DONE;
          end else begin
            ld.sda_rel = 1'b0;
            ld.owner   = 1'b1;
            ld.st      = ST_RS_C;
          end
        end
      end
      ST_RS_C: begin
        if (lq.cnt == HIGH_CYC) begin
          ld.scl_rel = 1'b0;
          ld.st      = ST_DONE;
        end
      end
      // SCL low: new data bit after the hold time
      ST_LOW: begin
        if (lq.cnt == HOLD_CYC) begin
          ld.sda_rel = drv_bit(lq.op, lq.bitcnt, lq.shreg[7], lq.ack_out);
        end
        if (lq.cnt == LOW_CYC) begin
          ld.scl_rel = 1'b1;
          ld.cnt     = '0;
          ld.st      = ST_HIGH;
        end
      end
      // SCL released: the high time counts only once the line is really high
      ST_HIGH: begin
        if (!scl_hi) begin
          ld.cnt = '0;
        end else if (arb_ev) begin
          ld.sda_rel = 1'b1;
          ld.scl_rel = 1'b1;
          ld.owner   = 1'b0;
          ld.arb     = 1'b1;
          ld.st      = ST_DONE;
        end else if (lq.cnt == HIGH_CYC) begin
          ld.scl_rel = 1'b0;
          ld.cnt     = '0;
          if (lq.bitcnt == ACK_BIT) begin
            ld.rdata = lq.shreg;
            ld.st    = ST_DONE;
          end else begin
            ld.bitcnt = lq.bitcnt + 4'h1;
            ld.st     = ST_LOW;
          end
        end
      end
      ST_STOP_A: begin
        if (lq.cnt == HOLD_CYC) begin
          ld.sda_rel = 1'b0;
        end
        if (lq.cnt == LOW_CYC) begin
          ld.scl_rel = 1'b1;
          ld.cnt     = '0;
          ld.st      = ST_STOP_B;
        end
      end
      ST_STOP_B: begin
        if (!scl_hi) begin
          ld.cnt = '0;
        end else if (lq.cnt == HIGH_CYC) begin
          ld.sda_rel = 1'b1;
          ld.cnt     = '0;
          ld.st      = ST_STOP_C;
        end
      end
      // Bus free time before another start may follow
      ST_STOP_C: begin
        if (lq.cnt == HIGH_CYC) begin
          ld.owner = 1'b0;
          ld.st    = ST_DONE;
        end
      end
      // Slave byte on the remote master's clock; SDA moves after SCL falls
      ST_SLV: begin
        if (arb_ev) begin
          ld.sda_rel = 1'b1;
          ld.arb     = 1'b1;
          ld.st      = ST_DONE;
        end else if (scl_fall) begin
          if (lq.bitcnt == ACK_BIT) begin
            ld.sda_rel = 1'b1;
            ld.rdata   = lq.shreg;
            ld.st      = ST_DONE;
          end else begin
            ld.bitcnt  = lq.bitcnt + 4'h1;
            ld.sda_rel = drv_bit(lq.op, lq.bitcnt + 4'h1, lq.shreg[7], lq.ack_out);
          end
        end
      end
      ST_DONE: begin
        ld.ack_t = ~lq.ack_t;
        ld.st    = ST_IDLE;
      end
      default: ld.st = ST_IDLE;
    endcase
  end

  // Synchronisers reset to the idle bus level so no false start is seen
  always_ff @(posedge lclk or negedge rst_n) begin
    if (!rst_n) begin
      lq         <= '0;
      lq.scl_s1  <= LINE_IDLE;
      lq.scl_s2  <= LINE_IDLE;
      lq.scl_p   <= LINE_IDLE;
      lq.sda_s1  <= LINE_IDLE;
      lq.sda_s2  <= LINE_IDLE;
      lq.sda_p   <= LINE_IDLE;
      lq.sda_rel <= LINE_IDLE;
      lq.scl_rel <= LINE_IDLE;
      lq.st      <= ST_IDLE;
    end else begin
      lq <= ld;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Enables are low while pulling; output data is always the low level
  assign sda_oe_n  = lq.sda_rel;
  assign scl_oe_n  = lq.scl_rel;
  assign sda_o     = PIN_LOW;
  assign scl_o     = PIN_LOW;
  assign cmd_ready = mq.ready;
  assign rsp       = mq.rsp;
  assign bus_busy  = mq.bsy_s2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_high_hold;
    lq.st == ST_HIGH ##1 lq.st == ST_HIGH;
  endsequence

  sequence s_stop_edge;
    lq.st == ST_STOP_B ##1 lq.st == ST_STOP_C;
  endsequence

  chk_sda_still_high: assert property (@(posedge lclk) disable iff (!rst_n)
    s_high_hold |-> $stable(lq.sda_rel))
    else $error("SDA moved while SCL high in a data bit");

  chk_arb_release: assert property (@(posedge lclk) disable iff (!rst_n)
    arb_ev && lq.st == ST_HIGH |=> lq.sda_rel && lq.scl_rel && lq.arb ##1 lq.st == ST_IDLE)
    else $error("Lines not released after arbitration loss");

  chk_start_shape: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_RS_B ##1 lq.st == ST_RS_C |-> lq.scl_rel && !lq.sda_rel && $past(lq.sda_rel))
    else $error("Start not made by SDA falling with SCL high");

  chk_stop_shape: assert property (@(posedge lclk) disable iff (!rst_n)
    s_stop_edge |-> lq.scl_rel && lq.sda_rel && !$past(lq.sda_rel))
    else $error("Stop not made by SDA rising with SCL high");

  chk_nine_bits: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_HIGH && lq.bitcnt == ACK_BIT && scl_hi && lq.cnt == HIGH_CYC
    |=> lq.st == ST_DONE && lq.rdata == $past(lq.shreg))
    else $error("Byte did not end after the ninth clock");

  chk_ack_release: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_HIGH && lq.bitcnt == ACK_BIT && is_tx(lq.op) |-> lq.sda_rel)
    else $error("Transmitter still drives SDA in acknowledge slot");

  chk_ack_drive: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_HIGH && lq.bitcnt == ACK_BIT && lq.op == OP_READ |-> lq.sda_rel == lq.ack_out)
    else $error("Master receiver sends wrong acknowledge level");

  chk_msb_first: assert property (@(posedge lclk) disable iff (!rst_n)
    smp_bit && lq.op == OP_WRITE && lq.bitcnt != ACK_BIT && !arb_ev
    |-> lq.sda_rel == lq.shreg[7])
    else $error("Transmitted bit is not the shifter MSB");

  chk_stretch_wait: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_HIGH && !scl_hi |=> lq.st == ST_HIGH && lq.scl_rel && lq.cnt == '0)
    else $error("Master moved on while SCL was held low");

  chk_start_busy: assert property (@(posedge lclk) disable iff (!rst_n)
    lq.st == ST_IDLE && new_req && mq.cmd_q.op == OP_START && !lq.owner && lq.busy
    |=> lq.st == ST_IDLE)
    else $error("Start issued while bus busy");

  chk_arb_report: assert property (@(posedge mclk) disable iff (!rst_n)
    mq.ack_s2 != mq.ack_seen |=> rsp.valid && rsp.arb_lost == $past(lq.arb) ##1 !rsp.valid)
    else $error("Answer pulse missing or arbitration flag lost");

endmodule : i2e_engine

// ==== verification/i2e_slave_model.sv ====
`timescale 1ns/100ps
// Far-side target: acks its address, keeps the last written byte,
// serves an incrementing byte stream on reads, may stretch SCL.
module i2e_slave_model #(
  parameter logic [6:0] ADDR     = 7'h2a,
  parameter logic [7:0] TX_FIRST = 8'h3c
) (
  input  wire logic sda,
  input  wire logic scl,
  input  wire logic stretch,
  output logic      sda_rel,
  output logic      scl_rel
);
  logic [7:0] sh;
  logic [7:0] rx_last;
  logic [7:0] tx_byte;
  logic       sel;
  logic       rd;
  logic       first;
  int         cnt;

  initial begin
    {sda_rel, scl_rel, sel, rd, first} = 5'b11000;
    tx_byte = TX_FIRST;
    rx_last = 8'h00;
    cnt = 0;
  end

  // Start and stop are SDA edges while SCL is high
  always @(negedge sda) if (scl) begin
    cnt = -1;
    first = 1'b1;
    sel = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    sel = 1'b0;
    first = 1'b0;
    sda_rel = 1'b1;
  end

  // Sample on SCL rise, MSB first; master nack ends the read
  always @(posedge scl) begin
    if (cnt < 8) sh = {sh[6:0], sda};
    else if (sel && rd && !first) begin
      if (sda) sel = 1'b0;
      tx_byte = tx_byte + 8'h01;
    end
  end

  // Change SDA only after SCL falls; nine clocks a byte
  always @(negedge scl) begin
    cnt = cnt + 1;
    if (cnt == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR); // Direction bit last
        rd = sh[0];
      end else if (sel && !rd) rx_last = sh;
      sda_rel = !(sel && (first || !rd)); // Pull low to ack
    end else if (cnt == 9) begin
      cnt = 0;
      first = 1'b0;
      sda_rel = !(sel && rd) || tx_byte[7];
    end else if (sel && rd && !first && cnt > 0) sda_rel = tx_byte[7-cnt];
    // A slow target holds SCL low after each bit
    if (stretch) begin
      scl_rel = 1'b0;
      #400 scl_rel = 1'b1;
    end
  end
endmodule : i2e_slave_model

// ==== verification/i2c_bus_protocol_engine_bench.sv ====
`timescale 1ns/100ps
module i2c_bus_protocol_engine_bench;
  import i2e_pkg::*;
  localparam logic [6:0] ADDR = 7'h2a;
  localparam logic [7:0] TX_FIRST = 8'h3c;
  localparam int LIMIT = 20000;
  localparam logic [7:0] RX_BYTE = 8'h69;
  logic mclk, lclk, rst_n, stretch, x_sda, x_scl, cmd_ready, bus_busy;
  logic sda_o, sda_oe_n, scl_o, scl_oe_n, m_sda, m_scl;
  i2e_cmd_s cmd;
  i2e_rsp_s rsp, r;
  int failures, n_compared, cycles;

  // Wired-AND lines with pull-ups; x_sda is a rival master
  wire sda_line = sda_oe_n & m_sda & x_sda;
  wire scl_line = scl_oe_n & m_scl & x_scl;

  i2e_engine #(.LOW_CYC(12'h008), .HIGH_CYC(12'h008), .HOLD_CYC(12'h002)) dut (
    .mclk(mclk), .rst_n(rst_n), .lclk(lclk), .cmd(cmd), .cmd_ready(cmd_ready),
    .rsp(rsp), .bus_busy(bus_busy), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .scl_i(scl_line), .scl_o(scl_o), .scl_oe_n(scl_oe_n));

  i2e_slave_model #(.ADDR(ADDR), .TX_FIRST(TX_FIRST)) m (
    .sda(sda_line), .scl(scl_line), .stretch(stretch), .sda_rel(m_sda), .scl_rel(m_scl));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Link clock with an unrelated phase
  initial begin
    lclk = 1'b0;
    #1.7;
    forever #3 lclk = ~lclk;
  end

  task automatic give_verdict;
    if (failures == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Command port: hold valid one edge, answer is a one-cycle pulse
  task automatic issue(input i2e_op_e o, input logic [7:0] d, input logic a);
    @(posedge mclk);
    cmd <= '{1'b1, o, d, a};
    @(posedge mclk);
    cmd.valid <= 1'b0;
  endtask : issue
  task automatic await;
    @(negedge mclk);
    while (rsp.valid !== 1'b1) @(negedge mclk);
    r = rsp;
  endtask : await
  task automatic xfer(input i2e_op_e o, input logic [7:0] d, input logic a);
    issue(o, d, a);
    await;
  endtask : xfer

  // Single write message to a given address
  task automatic msg_write(input logic [6:0] ad, input logic [7:0] d, input logic nak);
    xfer(OP_START, 8'h00, 1'b0);
    check(8'(bus_busy), 8'h01);
    xfer(OP_WRITE, {ad, 1'b0}, 1'b0);
    check(8'({r.arb_lost, r.ack_in}), 8'(nak));
    xfer(OP_WRITE, d, 1'b0);
    check(r.data, d);
    if (!nak) check(m.rx_last, d);
    xfer(OP_STOP, 8'h00, 1'b0);
    repeat (8) @(negedge mclk);
    check(8'(bus_busy), 8'h00);
  endtask : msg_write

  // Write a register index, restart, read two bytes with final nack
  task automatic t_combined;
    xfer(OP_START, 8'h00, 1'b0);
    xfer(OP_WRITE, {ADDR, 1'b0}, 1'b0);
    xfer(OP_WRITE, 8'h07, 1'b0);
    check(m.rx_last, 8'h07);
    xfer(OP_START, 8'h00, 1'b0);
    xfer(OP_WRITE, {ADDR, 1'b1}, 1'b0);
    check(8'(r.ack_in), 8'h00);
    xfer(OP_READ, 8'h00, 1'b0);
    check(r.data, TX_FIRST);
    xfer(OP_READ, 8'h00, 1'b1);
    check(r.data, TX_FIRST + 8'h01);
    xfer(OP_STOP, 8'h00, 1'b0);
  endtask : t_combined

  // A rival holds the bus; our start must wait for its stop
  task automatic t_busy;
    @(posedge mclk) x_sda <= 1'b0;
    repeat (20) @(negedge mclk);
    check(8'(bus_busy), 8'h01);
    issue(OP_START, 8'h00, 1'b0);
    repeat (300) @(negedge mclk);
    check({6'h00, cmd_ready, sda_oe_n}, 8'h01);
    @(posedge mclk) x_sda <= 1'b1;
    await;
    check(8'(sda_oe_n), 8'h00);
    xfer(OP_STOP, 8'h00, 1'b0);
  endtask : t_busy

  // Rival drives a zero where we send a one: both lines let go
  task automatic t_arb;
    xfer(OP_START, 8'h00, 1'b0);
    @(posedge mclk) x_sda <= 1'b0;
    xfer(OP_WRITE, 8'hff, 1'b0);
    check(8'(r.arb_lost), 8'h01);
    check({6'h00, sda_oe_n, scl_oe_n}, 8'h03);
    @(posedge mclk) x_sda <= 1'b1;
    repeat (8) @(negedge mclk);
    check(8'(bus_busy), 8'h00);
  endtask : t_arb

  // One bit clocked by a remote master: SDA set while SCL low, line sampled at the high
  task automatic rbit(input logic v, output logic s);
    repeat (5) @(posedge mclk);
    x_sda <= v;
    repeat (5) @(posedge mclk);
    x_scl <= 1'b1;
    repeat (10) @(posedge mclk);
    s = sda_line;
    x_scl <= 1'b0;
  endtask : rbit

  // Remote master reads one byte from us, then writes one that we acknowledge
  task automatic t_slave;
    logic [7:0] got;
    logic       s;
    @(posedge mclk) x_scl <= 1'b0;
    issue(OP_SLV_TX, 8'hc3, 1'b0);
    for (int i = 0; i < 8; i++) begin
      rbit(1'b1, s);
      got = {got[6:0], s};
    end
    rbit(1'b0, s);
    await;
    check(got, 8'hc3);
    check(8'({r.arb_lost, r.ack_in}), 8'h00);
    issue(OP_SLV_RX, 8'h00, 1'b0);
    for (int i = 7; i >= 0; i--) rbit(RX_BYTE[i], s);
    rbit(1'b1, s);
    await;
    check(8'(s), 8'h00);
    check(r.data, RX_BYTE);
    @(posedge mclk) x_sda <= 1'b1;
    @(posedge mclk) x_scl <= 1'b1;
  endtask : t_slave

  // Hang guard
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict;
    end
  end

  initial begin
    {rst_n, stretch, x_sda, x_scl} = 4'b0011;
    cmd = '0;
    {failures, n_compared, cycles} = '0;
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    check({5'h00, cmd_ready, sda_oe_n, scl_oe_n}, 8'h07);
    check({6'h00, sda_o, scl_o}, 8'h00);
    @(posedge mclk) rst_n <= 1'b1;
    msg_write(ADDR, 8'ha5, 1'b0);
    msg_write(7'h11, 8'h5a, 1'b1);
    t_combined;
    @(posedge mclk) stretch <= 1'b1;
    msg_write(ADDR, 8'h96, 1'b0);
    @(posedge mclk) stretch <= 1'b0;
    t_busy;
    t_arb;
    t_slave;
    give_verdict;
  end
endmodule : i2c_bus_protocol_engine_bench
